//--- hdl/fsr_dev.sv
module fsr_dev import fsr_pkg::*; #(
   parameter int SAMPLE_DIV = SAMPLE_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   fsr_link_if.dev link,
   input wire logic [11:0] adc_code_i,
   input wire logic [7:0] temp_code_i,
   input wire logic address_strap_pin_i,
   output logic trip_output_o
);
   localparam int SW = $clog2(SAMPLE_DIV + 1);

   // -------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------
   logic [2:0] scl_sy_reg, sda_sy_reg, strap_sy_reg;
   logic scl_reg, sda_reg, scl_d_reg, sda_d_reg;
   logic scl_rise, scl_fall, bus_start, bus_stop;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         scl_sy_reg <= 3'h7;
         sda_sy_reg <= 3'h7;
         strap_sy_reg <= 3'h7;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_sy_reg <= {scl_sy_reg[1:0], link.scl};
         sda_sy_reg <= {sda_sy_reg[1:0], link.sda};
         strap_sy_reg <= {strap_sy_reg[1:0], address_strap_pin_i};
         if (scl_sy_reg[1] == scl_sy_reg[2]) begin
            scl_reg <= scl_sy_reg[2];
         end
         if (sda_sy_reg[1] == sda_sy_reg[2]) begin
            sda_reg <= sda_sy_reg[2];
         end
         scl_d_reg <= scl_reg;
         sda_d_reg <= sda_reg;
      end
   end

   assign scl_rise = scl_reg & ~scl_d_reg;
   assign scl_fall = ~scl_reg & scl_d_reg;
   assign bus_start = scl_reg & scl_d_reg & sda_d_reg & ~sda_reg;
   assign bus_stop = scl_reg & scl_d_reg & ~sda_d_reg & sda_reg;

   // -------------------------------------------------
   // Address strap, caught once after reset
   // -------------------------------------------------
   logic [1:0] strap_cnt_reg;
   logic strap_done_reg, strap_low_reg;
   logic [7:0] addr_par_reg;
   logic [7:0] dev_addr;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         strap_cnt_reg <= 2'h0;
         strap_done_reg <= 1'b0;
         strap_low_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         if (strap_cnt_reg != 2'h3) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
         end else if (strap_sy_reg[1] == strap_sy_reg[2]) begin
            strap_low_reg <= ~strap_sy_reg[2];
            strap_done_reg <= 1'b1;
         end
      end
   end

   assign dev_addr = strap_low_reg ? STRAP_ADDR : addr_par_reg;

   // -------------------------------------------------
   // Sampling, filter, offset
   // -------------------------------------------------
   logic [SW-1:0] smp_cnt_reg;
   logic smp_tick;
   logic signed [19:0] filt_reg, x_in;
   logic signed [20:0] diff, step;
   logic [6:0] filt_m_reg;
   logic [15:0] offs_reg, field_reg, field_calc, ten16;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         smp_cnt_reg <= '0;
      end else if (smp_tick) begin
         smp_cnt_reg <= '0;
      end else begin
         smp_cnt_reg <= smp_cnt_reg + SW'(1);
      end
   end

   assign smp_tick = (smp_cnt_reg == SW'(SAMPLE_DIV - 1));
   assign x_in = {adc_code_i, {FRAC{1'b0}}};
   assign diff = {x_in[19], x_in} - {filt_reg[19], filt_reg};
   assign step = diff / $signed({14'h0000, filt_m_reg});
   // Ten-bit result from the 12-bit core
   assign ten16 = {{6{filt_reg[19]}}, filt_reg[19:10]};
   assign field_calc = ten16 * FIELD_STEP + offs_reg;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         filt_reg <= '0;
         field_reg <= 16'h0000;
      end else if (smp_tick) begin
         if (filt_m_reg <= 7'h01) begin
            filt_reg <= x_in;
         end else begin
            filt_reg <= filt_reg + step[19:0];
         end
         field_reg <= field_calc;
      end
   end

   // -------------------------------------------------
   // Trip comparator
   // -------------------------------------------------
   logic [15:0] ltl_reg, ltb_reg, utl_reg, utb_reg;
   logic flip_reg, act1_reg, act2_reg, en1, en2;
   logic signed [16:0] f, rel1, rel2;

   assign en1 = (ltl_reg != UNUSED);
   assign en2 = (utl_reg != UNUSED) && (utl_reg != ltl_reg);
   assign f = {field_calc[15], field_calc};
   assign rel1 = $signed({ltl_reg[15], ltl_reg})
      + ((ltb_reg == UNUSED) ? 17'sh0 : $signed({ltb_reg[15], ltb_reg}));
   assign rel2 = $signed({utl_reg[15], utl_reg})
      - ((utb_reg == UNUSED) ? 17'sh0 : $signed({utb_reg[15], utb_reg}));

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         act1_reg <= 1'b0;
         act2_reg <= 1'b0;
         trip_output_o <= 1'b0;
      end else begin
         if (smp_tick) begin
            if (!en1) begin
               act1_reg <= 1'b0;
            end else if (f < $signed({ltl_reg[15], ltl_reg})) begin
               act1_reg <= 1'b1;
            end else if (f > rel1) begin
               act1_reg <= 1'b0;
            end
            if (!en2) begin
               act2_reg <= 1'b0;
            end else if (f > $signed({utl_reg[15], utl_reg})) begin
               act2_reg <= 1'b1;
            end else if (f < rel2) begin
               act2_reg <= 1'b0;
            end
         end
         trip_output_o <= (act1_reg | act2_reg) ^ flip_reg;
      end
   end

   // -------------------------------------------------
   // Parameter store
   // -------------------------------------------------
   logic wr_go_reg;
   logic [15:0] wr_val_reg, rd_val;
   logic [7:0] ptr_reg;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ltl_reg <= RST_LTL;
         ltb_reg <= RST_LTB;
         utl_reg <= RST_UTL;
         utb_reg <= RST_UTB;
         flip_reg <= 1'b0;
         offs_reg <= RST_OFFS;
         filt_m_reg <= RST_FILT;
         addr_par_reg <= RST_ADDR;
      end else if (wr_go_reg) begin
         if (ptr_reg == REG_LTL) begin
            ltl_reg <= wr_val_reg;
         end else if (ptr_reg == REG_LTB) begin
            ltb_reg <= wr_val_reg;
         end else if (ptr_reg == REG_UTL) begin
            utl_reg <= wr_val_reg;
         end else if (ptr_reg == REG_UTB) begin
            utb_reg <= wr_val_reg;
         end else if (ptr_reg == REG_FLIP && wr_val_reg[15:1] == 15'h0) begin
            flip_reg <= wr_val_reg[0];
         end else if (ptr_reg == REG_OFFS) begin
            offs_reg <= wr_val_reg;
         end else if (ptr_reg == REG_FILT && wr_val_reg[15:7] == 9'h0
               && wr_val_reg[6:0] != 7'h00) begin
            filt_m_reg <= wr_val_reg[6:0];
         end else if (ptr_reg == REG_ADDR && wr_val_reg[15:8] == 8'h00
               && wr_val_reg[7:0] >= ADDR_MIN
               && wr_val_reg[7:0] <= ADDR_MAX) begin
            addr_par_reg <= wr_val_reg[7:0];
         end
      end
   end

   always_comb begin
      rd_val = 16'h0000;
      if (ptr_reg == REG_FIELD) begin
         rd_val = field_reg;
      end else if (ptr_reg == REG_TEMP) begin
         rd_val = {{8{temp_code_i[7]}}, temp_code_i};
      end else if (ptr_reg == REG_TRIP) begin
         rd_val = {15'h0000, trip_output_o};
      end else if (ptr_reg == REG_LTL) begin
         rd_val = ltl_reg;
      end else if (ptr_reg == REG_LTB) begin
         rd_val = ltb_reg;
      end else if (ptr_reg == REG_UTL) begin
         rd_val = utl_reg;
      end else if (ptr_reg == REG_UTB) begin
         rd_val = utb_reg;
      end else if (ptr_reg == REG_FLIP) begin
         rd_val = {15'h0000, flip_reg};
      end else if (ptr_reg == REG_OFFS) begin
         rd_val = offs_reg;
      end else if (ptr_reg == REG_FILT) begin
         rd_val = {9'h000, filt_m_reg};
      end else if (ptr_reg == REG_ADDR) begin
         rd_val = {8'h00, addr_par_reg};
      end
   end

   // -------------------------------------------------
   // Serial slave
   // -------------------------------------------------
   fsr_sl_state_type st_reg;
   logic [3:0] cnt_reg;
   logic [7:0] sh_reg, hi_reg, tx;
   logic [1:0] idx_reg;
   logic [15:0] rdw_reg;
   logic rw_reg, lo_reg, sda_oe_n_reg;

   assign tx = lo_reg ? rdw_reg[7:0] : rdw_reg[15:8];

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         st_reg <= S_IDLE;
         cnt_reg <= 4'h0;
         sh_reg <= 8'h00;
         hi_reg <= 8'h00;
         idx_reg <= 2'h0;
         ptr_reg <= 8'h00;
         rdw_reg <= 16'h0000;
         rw_reg <= 1'b0;
         lo_reg <= 1'b0;
         sda_oe_n_reg <= 1'b1;
         wr_go_reg <= 1'b0;
         wr_val_reg <= 16'h0000;
      end else begin
         wr_go_reg <= 1'b0;
         if (bus_start) begin
            st_reg <= S_ADDR;
            cnt_reg <= 4'h0;
            sda_oe_n_reg <= 1'b1;
         end else if (bus_stop) begin
            st_reg <= S_IDLE;
            sda_oe_n_reg <= 1'b1;
         end else if (scl_rise) begin
            case (st_reg)
               S_ADDR, S_WR: begin
                  sh_reg <= {sh_reg[6:0], sda_reg};
                  cnt_reg <= cnt_reg + 4'h1;
               end
               S_RD: cnt_reg <= cnt_reg + 4'h1;
               S_ACKM: if (sda_reg) st_reg <= S_IDLE;
               default: ;
            endcase
         end else if (scl_fall) begin
            case (st_reg)
               S_ADDR: if (cnt_reg == 4'h8) begin
                  if (strap_done_reg && sh_reg[7:1] == dev_addr[7:1]) begin
                     sda_oe_n_reg <= 1'b0;
                     rw_reg <= sh_reg[0];
                     idx_reg <= 2'h0;
                     lo_reg <= 1'b0;
                     rdw_reg <= rd_val;
                     st_reg <= S_ACKS;
                  end else begin
                     st_reg <= S_IDLE;
                  end
               end
               S_WR: if (cnt_reg == 4'h8) begin
                  sda_oe_n_reg <= 1'b0;
                  st_reg <= S_ACKS;
                  if (idx_reg == 2'h0) begin
                     ptr_reg <= sh_reg;
                     idx_reg <= 2'h1;
                  end else if (idx_reg == 2'h1) begin
                     hi_reg <= sh_reg;
                     idx_reg <= 2'h2;
                  end else begin
                     wr_go_reg <= 1'b1;
                     wr_val_reg <= {hi_reg, sh_reg};
                     idx_reg <= 2'h1;
                  end
               end
               S_ACKS: begin
                  cnt_reg <= 4'h0;
                  if (rw_reg) begin
                     sda_oe_n_reg <= tx[7];
                     st_reg <= S_RD;
                  end else begin
                     sda_oe_n_reg <= 1'b1;
                     st_reg <= S_WR;
                  end
               end
               S_RD: if (cnt_reg == 4'h8) begin
                  sda_oe_n_reg <= 1'b1;
                  lo_reg <= ~lo_reg;
                  st_reg <= S_ACKM;
               end else begin
                  sda_oe_n_reg <= tx[3'h7 - cnt_reg[2:0]];
               end
               S_ACKM: begin
                  cnt_reg <= 4'h0;
                  sda_oe_n_reg <= tx[7];
                  st_reg <= S_RD;
               end
               default: ;
            endcase
         end
      end
   end

   assign link.dev_sda_oe_n = sda_oe_n_reg;
   assign link.dev_sda_o = 1'b0;
   assign link.dev_scl_o = 1'b0;
   assign link.dev_scl_oe_n = 1'b1;
endmodule // fsr_dev

//--- hdl/fsr_host.sv
module fsr_host import fsr_pkg::*; #(
   parameter int NV_WAIT = NV_WAIT_CYC,
   parameter int QTR = SCL_QTR_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   fsr_link_if.host link,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o
);
   localparam int QW = $clog2(QTR + 1);
   localparam int NW = $clog2(NV_WAIT + 1);

   fsr_ms_state_type st_reg;
   logic [17:0] cmd_reg;
   logic [15:0] wdata_reg, rdata_reg;
   logic [2:0] sy_reg;
   logic sda_reg, nack_reg, scl_oe_n_reg, sda_oe_n_reg;
   logic [QW-1:0] q_reg;
   logic [NW-1:0] nv_reg;
   logic [1:0] ph_reg, byte_reg, last;
   logic [3:0] bit_reg;
   logic [7:0] sh_reg, txb;
   logic busy, go, qtick, reading;
   logic [1:0] op;

   // -------------------------------------------------
   // Command port
   // -------------------------------------------------
   assign busy = (st_reg != M_IDLE);
   assign go = reg_wr_i && reg_addr_i == H_CMD && !busy;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         cmd_reg <= 18'h0_0000;
         wdata_reg <= 16'h0000;
      end else begin
         if (go) begin
            cmd_reg <= reg_wdata_i[17:0];
         end
         if (reg_wr_i && reg_addr_i == H_WDATA && !busy) begin
            wdata_reg <= reg_wdata_i[15:0];
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (!reg_rd_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_addr_i == H_CMD) begin
         reg_rdata_o <= {14'h0000, cmd_reg};
      end else if (reg_addr_i == H_WDATA) begin
         reg_rdata_o <= {16'h0000, wdata_reg};
      end else if (reg_addr_i == H_RDATA) begin
         reg_rdata_o <= {16'h0000, rdata_reg};
      end else if (reg_addr_i == H_STAT) begin
         reg_rdata_o <= {29'h0000_0000, st_reg == M_NVW, nack_reg, busy};
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end

   // -------------------------------------------------
   // Bus master
   // -------------------------------------------------
   assign op = cmd_reg[CMD_OP_LSB +: 2];
   assign last = (op == OP_WRITE) ? 2'h3 : (op == OP_READ) ? 2'h2 : 2'h1;
   assign reading = (op == OP_READ) && (byte_reg != 2'h0);
   assign qtick = (q_reg == QW'(QTR - 1));

   always_comb begin
      txb = {cmd_reg[CMD_DEV_LSB + 1 +: 7], op == OP_READ};
      if (byte_reg == 2'h1) begin
         txb = cmd_reg[CMD_PTR_LSB +: 8];
      end else if (byte_reg == 2'h2) begin
         txb = wdata_reg[15:8];
      end else if (byte_reg == 2'h3) begin
         txb = wdata_reg[7:0];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         sy_reg <= 3'h7;
         sda_reg <= 1'b1;
      end else begin
         sy_reg <= {sy_reg[1:0], link.sda};
         if (sy_reg[1] == sy_reg[2]) begin
            sda_reg <= sy_reg[2];
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         st_reg <= M_IDLE;
         q_reg <= '0;
         nv_reg <= '0;
         ph_reg <= 2'h0;
         bit_reg <= 4'h0;
         byte_reg <= 2'h0;
         sh_reg <= 8'h00;
         rdata_reg <= 16'h0000;
         nack_reg <= 1'b0;
         scl_oe_n_reg <= 1'b1;
         sda_oe_n_reg <= 1'b1;
      end else if (st_reg == M_IDLE) begin
         if (go) begin
            st_reg <= M_START;
            q_reg <= '0;
            ph_reg <= 2'h0;
            nack_reg <= 1'b0;
         end
      end else if (st_reg == M_NVW) begin
         nv_reg <= nv_reg + NW'(1);
         if (nv_reg == NW'(NV_WAIT - 1)) begin
            st_reg <= M_IDLE;
         end
      end else if (!qtick) begin
         q_reg <= q_reg + QW'(1);
      end else begin
         q_reg <= '0;
         ph_reg <= ph_reg + 2'h1;
         case (st_reg)
            M_START: begin
               if (ph_reg == 2'h1) sda_oe_n_reg <= 1'b0;
               if (ph_reg == 2'h2) scl_oe_n_reg <= 1'b0;
               if (ph_reg == 2'h3) begin
                  st_reg <= M_BIT;
                  bit_reg <= 4'h0;
                  byte_reg <= 2'h0;
               end
            end
            M_BIT: begin
               if (ph_reg == 2'h0) begin
                  if (bit_reg == 4'h8) begin
                     sda_oe_n_reg <= !reading || byte_reg == last;
                  end else begin
                     sda_oe_n_reg <= reading || txb[3'h7 - bit_reg[2:0]];
                  end
               end
               if (ph_reg == 2'h1) scl_oe_n_reg <= 1'b1;
               if (ph_reg == 2'h2) begin
                  if (bit_reg != 4'h8) begin
                     sh_reg <= {sh_reg[6:0], sda_reg};
                  end else if (!reading && sda_reg) begin
                     nack_reg <= 1'b1;
                  end
               end
               if (ph_reg == 2'h3) begin
                  scl_oe_n_reg <= 1'b0;
                  bit_reg <= bit_reg + 4'h1;
                  if (bit_reg == 4'h8) begin
                     bit_reg <= 4'h0;
                     if (reading && byte_reg == 2'h1) rdata_reg[15:8] <= sh_reg;
                     if (reading && byte_reg == 2'h2) rdata_reg[7:0] <= sh_reg;
                     if (nack_reg || byte_reg == last) begin
                        st_reg <= M_STOP;
                     end else begin
                        byte_reg <= byte_reg + 2'h1;
                     end
                  end
               end
            end
            M_STOP: begin
               if (ph_reg == 2'h0) sda_oe_n_reg <= 1'b0;
               if (ph_reg == 2'h1) scl_oe_n_reg <= 1'b1;
               if (ph_reg == 2'h2) sda_oe_n_reg <= 1'b1;
               if (ph_reg == 2'h3) begin
                  nv_reg <= '0;
                  st_reg <= (op == OP_WRITE && !nack_reg) ? M_NVW : M_IDLE;
               end
            end
            default: st_reg <= M_IDLE;
         endcase
      end
   end

   assign link.host_scl_oe_n = scl_oe_n_reg;
   assign link.host_sda_oe_n = sda_oe_n_reg;
   assign link.host_scl_o = 1'b0;
   assign link.host_sda_o = 1'b0;
endmodule // fsr_host

//--- hdl/fsr_link_if.sv
interface fsr_link_if;
   logic dev_scl_o;
   logic dev_scl_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic host_scl_o;
   logic host_scl_oe_n;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic scl;
   logic sda;
   // Open-drain wired-AND with pull-up
   assign scl = ~((~dev_scl_oe_n & ~dev_scl_o)
                | (~host_scl_oe_n & ~host_scl_o));
   assign sda = ~((~dev_sda_oe_n & ~dev_sda_o)
                | (~host_sda_oe_n & ~host_sda_o));
   modport dev (input scl, input sda, output dev_scl_o,
      output dev_scl_oe_n, output dev_sda_o, output dev_sda_oe_n);
   modport host (input scl, input sda, output host_scl_o,
      output host_scl_oe_n, output host_sda_o, output host_sda_oe_n);
endinterface

//--- hdl/fsr_pkg.sv
// How it works
// - 12-bit conversion, 10-bit result precision
// - First-order IIR low-pass, cutoff 15000/(2*pi*m)
// - m of one bypasses filter; default off
// - Signed user offset added to field
// - Temperature readable over the serial bus
// - Two level/band pairs drive trip logic
// - Trip high above upper or below lower level; flip inverts
// - Default omnipolar, +-1 mT, 0.1 mT band
// - Master keeps upper above lower, bands >=0
// - 0xFFFF or equal partner marks unused
// - Bus address stored, writable, 16 to 238
// - Strap low forces address 16
// - Strap high uses stored address, default 72
// - Strap sampled only once after reset
// - Eight-bit address form, bit zero R/W
// - Pointer byte written first, reads follow it
// - Pointer is zero after reset
// - Field returned as two bytes, microtesla
// - Pointer holds until rewritten
// - Pointer byte then two value bytes
// - Unused bits zero; bad values ignored
// - Master waits 10 ms after each acknowledged value write
package fsr_pkg;
   localparam int CLK_HZ = 125_000_000;
   localparam int SAMPLE_HZ = 15000;
   localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
   localparam int NV_WAIT_MS = 10;
   localparam int NV_WAIT_CYC = CLK_HZ / 1000 * NV_WAIT_MS;
   localparam int SCL_PERIOD_NS = 2500;
   localparam int SCL_QTR_CYC = CLK_HZ / 1_000_000 * SCL_PERIOD_NS / 4000;
   localparam int FRAC = 8;
   localparam logic signed [15:0] FIELD_STEP = 16'sh0003;
   // Parameter map
   localparam logic [7:0] REG_FIELD = 8'h00;
   localparam logic [7:0] REG_TEMP = 8'h02;
   localparam logic [7:0] REG_TRIP = 8'h03;
   localparam logic [7:0] REG_LTL = 8'h10;
   localparam logic [7:0] REG_LTB = 8'h11;
   localparam logic [7:0] REG_UTL = 8'h12;
   localparam logic [7:0] REG_UTB = 8'h13;
   localparam logic [7:0] REG_FLIP = 8'h14;
   localparam logic [7:0] REG_OFFS = 8'h15;
   localparam logic [7:0] REG_FILT = 8'h16;
   localparam logic [7:0] REG_ADDR = 8'h17;
   localparam logic [15:0] RST_LTL = 16'hFC18;
   localparam logic [15:0] RST_LTB = 16'h0064;
   localparam logic [15:0] RST_UTL = 16'h03E8;
   localparam logic [15:0] RST_UTB = 16'h0064;
   localparam logic [15:0] RST_OFFS = 16'h0000;
   localparam logic [6:0] RST_FILT = 7'h01;
   localparam logic [7:0] RST_ADDR = 8'h48;
   localparam logic [15:0] UNUSED = 16'hFFFF;
   localparam logic [7:0] STRAP_ADDR = 8'h10;
   localparam logic [7:0] ADDR_MIN = 8'h10;
   localparam logic [7:0] ADDR_MAX = 8'hEE;
   // Host command port
   localparam logic [3:0] H_CMD = 4'h0;
   localparam logic [3:0] H_WDATA = 4'h4;
   localparam logic [3:0] H_RDATA = 4'h8;
   localparam logic [3:0] H_STAT = 4'hC;
   localparam int CMD_DEV_LSB = 0;
   localparam int CMD_PTR_LSB = 8;
   localparam int CMD_OP_LSB = 16;
   localparam logic [1:0] OP_PTR = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam int ST_BUSY = 0;
   localparam int ST_NACK = 1;
   localparam int ST_NVW = 2;
   typedef enum logic [5:0] {
      S_IDLE = 6'h01, S_ADDR = 6'h02, S_WR = 6'h04,
      S_ACKS = 6'h08, S_RD = 6'h10, S_ACKM = 6'h20
   } fsr_sl_state_type;
   typedef enum logic [4:0] {
      M_IDLE = 5'h01, M_START = 5'h02, M_BIT = 5'h04,
      M_STOP = 5'h08, M_NVW = 5'h10
   } fsr_ms_state_type;
endpackage

//--- sim/fsr_checker.sv
module fsr_checker (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic dev_scl_oe_n,
   input wire logic dev_sda_oe_n,
   input wire logic host_scl_oe_n,
   input wire logic host_sda_oe_n,
   input wire logic scl,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------
   // Wire rules
   // ----------------------------
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   a_clk_host: assert property (
      dev_scl_oe_n && scl == host_scl_oe_n) else $error("scl owner");
   a_sda_wired: assert property (
      sda == (host_sda_oe_n && dev_sda_oe_n)) else $error("sda level");
   a_reset_idle: assert property (rst_n_i && !$past(rst_n_i) |->
      dev_sda_oe_n && host_sda_oe_n && host_scl_oe_n) else $error("rst");
   a_dev_scl_low: assert property (
      $changed(dev_sda_oe_n) |-> !scl) else $error("sda moved");
   a_ack_held: assert property (
      $fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8]) else $error("ack");
   a_scl_low_max: assert property (
      !scl |-> ##[1:64] scl) else $error("scl low");
   a_scl_high_min: assert property (
      $rose(scl) |-> scl [*8]) else $error("scl high");
   a_sda_stable: assert property (
      $rose(scl) |-> ##1 $stable(sda) [*2]) else $error("sda");
   c_ack: cover property ($fell(dev_sda_oe_n));
   c_stop: cover property (scl && $rose(sda));
   c_reset: cover property (rst_n_i && !$past(rst_n_i));
endmodule // fsr_checker

//--- sim/testbench.sv
module testbench import fsr_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 0, rst_n_i = 0, reg_wr = 0, reg_rd = 0, strap = 1;
   logic [3:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata, d;
   logic [11:0] adc = '0;
   logic [7:0] dev = 8'h48;
   logic [7:0] temp = 8'hE7;
   logic trip;
   int n_fail = 0, n_tests = 0;
   fsr_link_if link ();
   fsr_dev #(.SAMPLE_DIV(20)) fsr_dev_inst (.clk_sys_i, .rst_n_i,
      .link(link.dev), .adc_code_i(adc), .temp_code_i(temp),
      .address_strap_pin_i(strap), .trip_output_o(trip));
   fsr_host #(.NV_WAIT(50), .QTR(8)) fsr_host_inst (.clk_sys_i, .rst_n_i,
      .link(link.host), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
   fsr_checker fsr_checker_inst (.clk_sys_i, .rst_n_i, .scl(link.scl),
      .dev_scl_oe_n(link.dev_scl_oe_n), .dev_sda_oe_n(link.dev_sda_oe_n),
      .host_scl_oe_n(link.host_scl_oe_n), .sda(link.sda),
      .host_sda_oe_n(link.host_sda_oe_n));
   initial forever #4 clk_sys_i = ~clk_sys_i;
   // ----------------------------
   // Bus and check tasks
   // ----------------------------
   task summarize;
      $display("n_fail=%0d n_tests=%0d", n_fail, n_tests);
      if (n_fail == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_sys_i);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge clk_sys_i);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task xfer(input logic [1:0] op, input logic [7:0] p, input logic [15:0] v);
      wr(H_WDATA, {16'h0000, v});
      wr(H_CMD, {14'h0000, op, p, dev});
      rd(H_STAT);
      for (int i = 0; i < 2000 && d[ST_BUSY] !== 1'b0; i++) rd(H_STAT);
      if (d[ST_BUSY] !== 1'b0) begin
         n_fail++;
         summarize();
      end
   endtask
   task get(input logic [7:0] p, input logic [15:0] e);
      xfer(OP_PTR, p, 16'h0000);
      xfer(OP_READ, p, 16'h0000);
      rd(H_RDATA);
      chk(d, {16'h0000, e});
   endtask
   task settle(input logic [11:0] code);
      @(posedge clk_sys_i) adc <= code;
      repeat (60) @(posedge clk_sys_i);
      #1;
   endtask
   // ----------------------------
   // Scenarios
   // ----------------------------
   task s_field;
      settle(12'h400);
      xfer(OP_READ, 8'h00, 16'h0000);
      rd(H_RDATA);
      chk(d, 32'h0000_0300);
      get(REG_FIELD, 16'h0300);
      xfer(OP_WRITE, REG_OFFS, 16'h0005);
      get(REG_FIELD, 16'h0305);
      xfer(OP_READ, 8'h00, 16'h0000);
      rd(H_RDATA);
      chk(d, 32'h0000_0305);
      xfer(OP_WRITE, REG_OFFS, 16'h0000);
      // Halving steps stop one fraction step short of a rising input
      settle(12'h000);
      xfer(OP_WRITE, REG_FILT, 16'h0002);
      settle(12'h400);
      get(REG_FIELD, 16'h02FD);
      xfer(OP_WRITE, REG_FILT, 16'h0001);
   endtask
   task s_defaults;
      get(REG_LTL, 16'hFC18);
      get(REG_UTB, 16'h0064);
      get(REG_FILT, 16'h0001);
      get(REG_TEMP, 16'hFFE7);
      @(posedge clk_sys_i) temp <= 8'h19;
      get(REG_TEMP, 16'h0019);
   endtask
   task automatic s_trip;
      logic [11:0] codes [5] = '{12'h600, 12'h500, 12'h400, 12'hA00, 12'h400};
      logic [4:0] trips = 5'b01011;
      for (int i = 0; i < 5; i++) begin
         settle(codes[i]);
         chk({31'h0, trip}, {31'h0, trips[i]});
      end
      xfer(OP_WRITE, REG_FLIP, 16'h0001);
      settle(12'h400);
      chk({31'h0, trip}, 32'h1);
      xfer(OP_WRITE, REG_FLIP, 16'h0000);
      xfer(OP_WRITE, REG_UTB, 16'h0000);
      xfer(OP_WRITE, REG_UTL, 16'hFFFF);
      settle(12'h600);
      chk({31'h0, trip}, 32'h0);
   endtask
   task s_addr;
      xfer(OP_WRITE, REG_ADDR, 16'h0005);
      get(REG_ADDR, 16'h0048);
      @(posedge clk_sys_i) strap <= 1'b0;
      dev = 8'h10;
      xfer(OP_PTR, 8'h00, 16'h0000);
      chk({31'h0, d[ST_NACK]}, 32'h1);
      dev = 8'h48;
      get(REG_ADDR, 16'h0048);
   endtask
   task s_strap;
      @(posedge clk_sys_i) rst_n_i <= 1'b0;
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (16) @(posedge clk_sys_i);
      dev = 8'h10;
      get(REG_ADDR, 16'h0048);
   endtask
   initial begin
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (16) @(posedge clk_sys_i);
      s_field();
      s_defaults();
      s_trip();
      s_addr();
      s_strap();
      summarize();
   end
endmodule // testbench
